// ===== design/asf_audio_slot_fifo.sv
`timescale 1ns/1ps
module asf_audio_slot_fifo import asf_pkg::*; (
	// Core clock and reset
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	// Link clock and pins
	input  wire logic                    link_clk,
	input  wire logic                    frame_sync,
	input  wire logic                    serial_rx_data,
	output logic                         serial_tx_data_pin_o,
	output logic                         serial_tx_data_pin_oe_n,
	// Static configuration
	input  wire logic                    interface_enable_bit,
	input  wire logic [SLOT_W-1:0]       frame_last_slot,
	input  wire logic [SLOT_N-1:0]       rx_slot_enables,
	input  wire logic [SLOT_N-1:0]       rx_dma_slot_routing,
	input  wire logic [SLOT_N-1:0]       rx_dma_request_enable,
	input  wire logic [PTR_W-1:0]        rx_warning_level,
	// Transmit status and control register
	input  wire logic                    tsc_wr,
	input  wire logic [15:0]             tsc_wdata,
	output logic      [15:0]             tsc_rdata,
	// Receive FIFO access
	input  wire logic                    rx_rd,
	output logic      [WORD_W-1:0]       rx_rdata,
	output logic                         rx_fifo_full_flag,
	output logic                         rx_fifo_empty_flag,
	output logic                         rx_overflow_flag,
	input  wire logic                    rx_overflow_clear,
	// Transmit data register
	input  wire logic                    tx_wr,
	input  wire logic [WORD_W-1:0]       tx_wdata,
	// Receive DMA
	output logic [SLOT_N-1:0][WORD_W-1:0] rx_dma_data_reg,
	input  wire logic [SLOT_N-1:0]       rx_dma_ack,
	output logic      [SLOT_N-1:0]       rx_dma_req,
	// Transmit DMA
	input  wire logic [SLOT_N-1:0]       tx_dma_wr,
	input  wire logic [WORD_W-1:0]       tx_dma_wdata,
	output logic      [SLOT_N-1:0]       tx_dma_req,
	// Interrupts
	output logic                         rx_irq,
	output logic                         tx_irq
);

	// ****************************************
	// Declarations
	// ****************************************
	asf_link_state_t      lk_state_r;
	logic [1:0]           lk_pins;
	logic                 lk_fs;
	logic                 lk_rxd;
	logic [11:0]          lk_cfg;
	logic                 lk_en;
	logic [SLOT_N-1:0]    lk_rx_en;
	logic [SLOT_N-1:0]    lk_tx_en;
	logic [SLOT_W-1:0]    lk_last;
	logic                 lk_ack;
	logic [BIT_W-1:0]     bit_r;
	logic [SLOT_W-1:0]    slot_r;
	logic [BIT_W-1:0]     bit_now;
	logic [SLOT_W-1:0]    slot_now;
	logic [SLOT_W-1:0]    slot_next;
	logic                 lk_active;
	logic [WORD_W-1:0]    rx_shift_register;
	logic [WORD_W-1:0]    rx_word_r;
	logic [SLOT_W-1:0]    rx_slot_r;
	logic                 rx_tgl_r;
	logic [WORD_W-1:0]    tx_shift_register;
	logic [SLOT_W-1:0]    tx_req_slot_r;
	logic                 tx_req_tgl_r;
	logic                 drive_r;

	logic [1:0]           c_tgl;
	logic                 c_rx_p_r;
	logic                 c_tx_p_r;
	logic                 rx_evt;
	logic                 tx_evt;
	logic                 rx_to_dma;
	logic                 rx_fifo_wr;
	logic [PTR_W:0]       rx_count;
	logic [11:0]          tsc_cfg_r;
	logic                 tx_under_ok_r;
	logic [SLOT_N-1:0]    tx_slot_enables;
	logic [SLOT_N-1:0]    tx_dma_slot_routing;
	logic [PTR_W-1:0]     tx_warning_level;
	logic [WORD_W-1:0]    tx_hold_r;
	logic                 tx_ack_tgl_r;
	logic [SLOT_N-1:0][WORD_W-1:0] tx_dma_data_reg;
	logic [SLOT_N-1:0]    tx_dma_full_r;
	logic [SLOT_N-1:0]    rx_dma_full_r;
	logic                 tx_slot_on;
	logic                 tx_slot_dma;
	logic                 tx_fifo_rd;
	logic                 tx_underrun;
	logic [WORD_W-1:0]    tx_fifo_data;
	logic [WORD_W-1:0]    tx_fifo_prev;
	logic                 tx_fifo_full_flag;
	logic                 tx_fifo_empty_flag;
	logic                 tx_almost_empty_flag;
	logic [PTR_W:0]       tx_count;

	// ****************************************
	// Link domain: pin and config crossing
	// ****************************************
	asf_sync #(.W(2)) u_pin_sync (
		.clk   (link_clk),
		.rst_n (rst_n),
		.d     ({frame_sync, serial_rx_data}),
		.q     (lk_pins)
	);

	// Enables are quasi-static; software changes them only between frames
	asf_sync #(.W(12)) u_cfg_sync (
		.clk   (link_clk),
		.rst_n (rst_n),
		.d     ({interface_enable_bit, tx_ack_tgl_r, frame_last_slot,
		         rx_slot_enables, tx_slot_enables}),
		.q     (lk_cfg)
	);

	assign lk_fs     = lk_pins[1];
	assign lk_rxd    = lk_pins[0];
	assign lk_en     = lk_cfg[11];
	assign lk_ack    = lk_cfg[10];
	assign lk_last   = lk_cfg[9:8];
	assign lk_rx_en  = lk_cfg[7:4];
	assign lk_tx_en  = lk_cfg[3:0];
	assign bit_now   = lk_fs ? '0 : bit_r;
	assign slot_now  = lk_fs ? '0 : slot_r;
	// Slot counter wraps at frame length, so later slot bits never act
	assign slot_next = (slot_now == lk_last) ? '0 : slot_now + 1'b1;
	assign lk_active = lk_en && (lk_fs || lk_state_r == LNK_RUN);

	// ****************************************
	// Link domain: frame and slot timing
	// ****************************************
	always_ff @(posedge link_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lk_state_r <= LNK_IDLE;
			bit_r      <= '0;
			slot_r     <= '0;
		end
		else
		begin
			case (lk_state_r)
				LNK_IDLE:
					if (lk_en && lk_fs)
						lk_state_r <= LNK_RUN;
				LNK_RUN:
					if (!lk_en)
						lk_state_r <= LNK_IDLE;
				default:
					lk_state_r <= LNK_IDLE;
			endcase
			if (lk_active)
			begin
				bit_r <= bit_now + 1'b1;
				if (bit_now == LAST_BIT)
					slot_r <= slot_next;
				else
					slot_r <= slot_now;
			end
		end
	end

	// ****************************************
	// Link domain: receive shifter
	// ****************************************
	always_ff @(posedge link_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_shift_register <= '0;
			rx_word_r         <= '0;
			rx_slot_r         <= '0;
			rx_tgl_r          <= 1'b0;
		end
		else if (lk_active)
		begin
			rx_shift_register <= {rx_shift_register[WORD_W-2:0], lk_rxd};
			// Only enabled slots are handed to the core
			if (bit_now == LAST_BIT && lk_rx_en[slot_now])
			begin
				rx_word_r <= {rx_shift_register[WORD_W-2:0], lk_rxd};
				rx_slot_r <= slot_now;
				rx_tgl_r  <= !rx_tgl_r;
			end
		end
	end

	// ****************************************
	// Link domain: transmit shifter and pin
	// ****************************************
	always_ff @(posedge link_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_shift_register <= '0;
			tx_req_slot_r     <= '0;
			tx_req_tgl_r      <= 1'b0;
			drive_r           <= 1'b0;
		end
		else if (!lk_active)
			drive_r <= 1'b0;
		else if (bit_now == '0)
		begin
			// Hold word is stable once the core answered the last request
			tx_shift_register <= (lk_ack == tx_req_tgl_r) ? tx_hold_r : '0;
			tx_req_slot_r     <= slot_next;
			tx_req_tgl_r      <= !tx_req_tgl_r;
			drive_r           <= lk_tx_en[slot_now];
		end
		else
			tx_shift_register <= {tx_shift_register[WORD_W-2:0], 1'b0};
	end

	assign serial_tx_data_pin_o    = tx_shift_register[WORD_W-1];
	assign serial_tx_data_pin_oe_n = !drive_r;

	// ****************************************
	// Core domain: event crossing
	// ****************************************
	asf_sync #(.W(2)) u_evt_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     ({rx_tgl_r, tx_req_tgl_r}),
		.q     (c_tgl)
	);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			c_rx_p_r <= 1'b0;
			c_tx_p_r <= 1'b0;
		end
		else
		begin
			c_rx_p_r <= c_tgl[1];
			c_tx_p_r <= c_tgl[0];
		end
	end

	assign rx_evt = c_tgl[1] ^ c_rx_p_r;
	assign tx_evt = c_tgl[0] ^ c_tx_p_r;

	// ****************************************
	// Core domain: receive path
	// ****************************************
	assign rx_to_dma  = rx_slot_enables[rx_slot_r]
	                  && rx_dma_slot_routing[rx_slot_r];
	assign rx_fifo_wr = rx_evt && !rx_to_dma;

	asf_fifo #(.DW(WORD_W), .AW(PTR_W)) u_rx_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.wr_en     (rx_fifo_wr),
		.wr_data   (rx_word_r),
		.rd_en     (rx_rd),
		.rd_data   (rx_rdata),
		.prev_data (),
		.full      (rx_fifo_full_flag),
		.empty     (rx_fifo_empty_flag),
		.count     (rx_count)
	);

	// Overflow event wins over a clear in the same cycle
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rx_overflow_flag <= 1'b0;
		else if (rx_fifo_wr && rx_fifo_full_flag)
			rx_overflow_flag <= 1'b1;
		else if (rx_overflow_clear)
			rx_overflow_flag <= 1'b0;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_dma_data_reg <= '0;
			rx_dma_full_r   <= '0;
		end
		else
		begin
			for (int n = 0; n < SLOT_N; n++)
			begin
				if (rx_evt && rx_to_dma && rx_slot_r == SLOT_W'(n))
				begin
					rx_dma_data_reg[n] <= rx_word_r;
					rx_dma_full_r[n]   <= 1'b1;
				end
				else if (rx_dma_ack[n])
					rx_dma_full_r[n] <= 1'b0;
			end
		end
	end

	// Overflow holds both off until software clears the flag
	assign rx_dma_req = rx_dma_full_r & rx_dma_request_enable
	                  & rx_dma_slot_routing & rx_slot_enables
	                  & {SLOT_N{!rx_overflow_flag}};
	assign rx_irq     = (rx_count > {1'b0, rx_warning_level})
	                  && !rx_overflow_flag;

	// ****************************************
	// Core domain: transmit status and control
	// ****************************************
	assign tx_slot_enables     = tsc_cfg_r[TSC_TX_SLOT_ENABLES_LSB-4 +: SLOT_N];
	assign tx_dma_slot_routing = tsc_cfg_r[TSC_TXDS_LSB-4 +: SLOT_N];
	assign tx_warning_level    = tsc_cfg_r[TSC_LVL_LSB-4 +: PTR_W];

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			tsc_cfg_r <= TSC_RESET[15:4];
		else if (tsc_wr)
			tsc_cfg_r <= tsc_wdata[15:4] & TSC_WR_MASK[15:4];
	end

	// Underrun wins over a write of 1 that re-arms the flag
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			tx_under_ok_r <= TSC_RESET[TSC_UNDER];
		else if (tx_underrun)
			tx_under_ok_r <= 1'b0;
		else if (tsc_wr && tsc_wdata[TSC_UNDER])
			tx_under_ok_r <= 1'b1;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			tsc_rdata <= TSC_RESET;
		else
			tsc_rdata <= {tsc_cfg_r, tx_almost_empty_flag, tx_fifo_full_flag,
			              tx_fifo_empty_flag, tx_under_ok_r};
	end

	// ****************************************
	// Core domain: transmit path
	// ****************************************
	assign tx_slot_on  = tx_evt && tx_slot_enables[tx_req_slot_r];
	assign tx_slot_dma = tx_dma_slot_routing[tx_req_slot_r];
	assign tx_fifo_rd  = tx_slot_on && !tx_slot_dma && !tx_fifo_empty_flag;
	assign tx_underrun = tx_slot_on && !tx_slot_dma && tx_fifo_empty_flag;

	asf_fifo #(.DW(WORD_W), .AW(PTR_W)) u_tx_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.wr_en     (tx_wr),
		.wr_data   (tx_wdata),
		.rd_en     (tx_fifo_rd),
		.rd_data   (tx_fifo_data),
		.prev_data (tx_fifo_prev),
		.full      (tx_fifo_full_flag),
		.empty     (tx_fifo_empty_flag),
		.count     (tx_count)
	);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_hold_r    <= '0;
			tx_ack_tgl_r <= 1'b0;
		end
		else if (tx_evt)
		begin
			tx_ack_tgl_r <= !tx_ack_tgl_r;
			if (tx_slot_on && tx_slot_dma)
				tx_hold_r <= tx_dma_data_reg[tx_req_slot_r];
			else if (tx_underrun)
				// Back one and forward one: pointer nets unchanged
				tx_hold_r <= tx_fifo_prev;
			else if (tx_slot_on)
				tx_hold_r <= tx_fifo_data;
		end
	end

	// A DMA write in the cycle of consumption keeps the register full
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_dma_data_reg <= '0;
			tx_dma_full_r   <= '0;
		end
		else
		begin
			for (int n = 0; n < SLOT_N; n++)
			begin
				if (tx_dma_wr[n])
				begin
					tx_dma_data_reg[n] <= tx_dma_wdata;
					tx_dma_full_r[n]   <= 1'b1;
				end
				else if (tx_slot_on && tx_slot_dma
				         && tx_req_slot_r == SLOT_W'(n))
					tx_dma_full_r[n] <= 1'b0;
			end
		end
	end

	assign tx_almost_empty_flag = tx_count <= {1'b0, tx_warning_level};
	// After an underrun both stay off until the flag is re-armed
	assign tx_dma_req = ~tx_dma_full_r & tx_dma_slot_routing
	                  & tx_slot_enables & {SLOT_N{tx_under_ok_r}};
	assign tx_irq     = tx_almost_empty_flag && tx_under_ok_r;

endmodule // asf_audio_slot_fifo

// ===== design/asf_pkg.sv
//
// Summary of operation
// - Word completed while receive FIFO full is dropped; write pointer holds still.
// - Receive overflow raises no receive interrupt and no receive DMA request.
// - Receive overflow flag reads 1 after an overflow, 0 otherwise.
// - Receive slot enables: one bit per slot, four slots, unused slots ignored.
// - Receive enable bit n captures slot n; whole field clears at reset.
// - Enabled slot with receive routing set goes to its DMA register, not FIFO.
// - Receive DMA request n: register n full and request enable n set.
// - Receive interrupt when occupancy exceeds warning level; level resets to 0.
// - Transmit status and control register loads F003h at reset, read/write.
// - Transmit almost-empty reads 1 at or below the warning limit.
// - Transmit empty: pointers equal and last access was a read.
// - Transmit full: pointers equal and last access was a write.
// - Underrun steps read pointer back one, resends word, no interrupt or request.
// - Transmit underrun flag is inverted: 0 means an underrun happened.
// - Transmit pin driven only in enabled slots, high impedance otherwise.
// - Routed transmit slot reads its DMA register; request while that is empty.
// - Transmit interrupt when occupancy at or below level; level resets to Fh.
// - Receive full: pointers equal and last access was a write.
// - Receive empty: pointers equal and last access was a read.
//
package asf_pkg;

	// ****************************************
	// Geometry
	// ****************************************
	localparam int WORD_W = 16;
	localparam int SLOT_N = 4;
	localparam int SLOT_W = 2;
	localparam int PTR_W  = 4;
	localparam int BIT_W  = 4;
	localparam logic [BIT_W-1:0] LAST_BIT = 4'h F;

	// ****************************************
	// Transmit status and control layout
	// ****************************************
	localparam logic [15:0] TSC_RESET    = 16'hF003;
	localparam logic [15:0] TSC_WR_MASK  = 16'hFFF0;
	localparam int          TSC_UNDER    = 0;
	localparam int          TSC_EMPTY    = 1;
	localparam int          TSC_FULL     = 2;
	localparam int          TSC_AEMPTY   = 3;
	localparam int          TSC_TX_SLOT_ENABLES_LSB = 4;
	localparam int          TSC_TXDS_LSB = 8;
	localparam int          TSC_LVL_LSB  = 12;

	// ****************************************
	// Reset values and timing
	// ****************************************
	localparam logic [PTR_W-1:0] RX_LEVEL_RESET = 4'h0;
	localparam int DISABLE_WAIT_LINK_CYCLES = 10;

	typedef enum logic {LNK_IDLE, LNK_RUN} asf_link_state_t;

endpackage

// ===== design/asf_sync.sv
`timescale 1ns/1ps
module asf_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_r;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_r <= '0;
			q      <= '0;
		end
		else
		begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule // asf_sync

// ===== design/asf_fifo.sv
`timescale 1ns/1ps
module asf_fifo import asf_pkg::*; #(
	parameter int DW = WORD_W,
	parameter int AW = PTR_W
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          rst_n,
	// Fill side
	input  wire logic          wr_en,
	input  wire logic [DW-1:0] wr_data,
	// Drain side
	input  wire logic          rd_en,
	output logic      [DW-1:0] rd_data,
	output logic      [DW-1:0] prev_data,
	// Status
	output logic               full,
	output logic               empty,
	output logic      [AW:0]   count
);

	logic [DW-1:0] mem_r [2**AW];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic          last_wr_r;
	logic          do_wr;
	logic          do_rd;

	// A write into a full FIFO is dropped, pointer untouched
	assign do_wr = wr_en && !full;
	assign do_rd = rd_en && !empty;
	assign full  = (wp_r == rp_r) && last_wr_r;
	assign empty = (wp_r == rp_r) && !last_wr_r;
	assign count = full ? (AW+1)'(2**AW) : {1'b0, AW'(wp_r - rp_r)};
	assign rd_data   = mem_r[rp_r];
	assign prev_data = mem_r[AW'(rp_r - 1'b1)];

	always_ff @(posedge clk)
	begin
		if (do_wr)
			mem_r[wp_r] <= wr_data;
	end

	// Pointers wrap at the depth
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wp_r      <= '0;
			rp_r      <= '0;
			last_wr_r <= 1'b0;
		end
		else
		begin
			wp_r <= wp_r + AW'(do_wr);
			rp_r <= rp_r + AW'(do_rd);
			if (do_wr != do_rd)
				last_wr_r <= do_wr;
		end
	end

endmodule // asf_fifo

// ===== verification/asf_chk.sv
`timescale 1ns/1ps
module asf_chk import asf_pkg::*; (
	// Clock and reset
	input wire logic              clk,
	input wire logic              rst_n,
	// Watched ports
	input wire logic              serial_tx_data_pin_oe_n,
	input wire logic              tsc_wr,
	input wire logic [15:0]       tsc_wdata,
	input wire logic [15:0]       tsc_rdata,
	input wire logic              rx_rd,
	input wire logic              rx_fifo_full_flag,
	input wire logic              rx_fifo_empty_flag,
	input wire logic              rx_overflow_flag,
	input wire logic [SLOT_N-1:0] rx_dma_req,
	input wire logic [SLOT_N-1:0] tx_dma_wr,
	input wire logic [SLOT_N-1:0] tx_dma_req,
	input wire logic              rx_irq,
	input wire logic              tx_irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Slots off long enough for a running slot to drain
	logic [5:0] idle_r;
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			idle_r <= '0;
		else if (tsc_rdata[7:4] != 4'h0)
			idle_r <= '0;
		else if (idle_r != 6'h3F)
			idle_r <= idle_r + 6'h01;

	sequence s_tsc_store;
		tsc_wr ##2 1'b1;
	endsequence

	a_tsc_write_back: assert property (s_tsc_store |-> (tsc_rdata & TSC_WR_MASK)
		== ($past(tsc_wdata, 2) & TSC_WR_MASK))
		else $error("tsc readback differs from write");
	a_tx_flag_excl: assert property (!(tsc_rdata[TSC_EMPTY] && tsc_rdata[TSC_FULL]))
		else $error("tx empty and full together");
	a_rx_flag_excl: assert property (!(rx_fifo_full_flag && rx_fifo_empty_flag))
		else $error("rx empty and full together");
	a_rx_ovf_quiet: assert property (rx_overflow_flag |-> !rx_irq && rx_dma_req == '0)
		else $error("request during rx overflow");
	a_ovf_when_full: assert property ($rose(rx_overflow_flag) |-> rx_fifo_full_flag)
		else $error("overflow without full fifo");
	a_rx_full_hold: assert property (rx_fifo_full_flag && !rx_rd |=> rx_fifo_full_flag)
		else $error("rx full dropped without read");
	a_rx_irq_level: assert property ((!rx_overflow_flag && (rx_fifo_full_flag
		|| rx_fifo_empty_flag)) |-> rx_irq == rx_fifo_full_flag)
		else $error("rx irq wrong at fifo bound");
	a_tx_under_quiet: assert property ((!tsc_rdata[TSC_UNDER] && !$past(tsc_wr))
		|-> !tx_irq && tx_dma_req == '0)
		else $error("tx request during underrun");
	a_dma_load_req: assert property (|tx_dma_wr |=> (tx_dma_req & $past(tx_dma_wr)) == '0)
		else $error("tx dma request after load");
	a_pin_idle: assert property (idle_r >= 6'h32 |-> serial_tx_data_pin_oe_n)
		else $error("tx pin driven with no slot");
endmodule // asf_chk

bind asf_audio_slot_fifo asf_chk u_chk (.clk, .rst_n, .serial_tx_data_pin_oe_n,
	.tsc_wr, .tsc_wdata, .tsc_rdata, .rx_rd, .rx_fifo_full_flag,
	.rx_fifo_empty_flag, .rx_overflow_flag, .rx_dma_req, .tx_dma_wr,
	.tx_dma_req, .rx_irq, .tx_irq);

// ===== verification/asf_codec.sv
`timescale 1ns/1ps
module asf_codec (
	// Control from the bench
	input  wire logic             run,
	input  wire logic [1:0]       last_slot,
	input  wire logic [3:0][15:0] words,
	// Link pins
	input  wire logic             pin,
	input  wire logic             oe_n,
	output logic                  link_clk,
	output logic                  frame_sync,
	output logic                  sdata
);
	logic [15:0] shift;
	int          nbits;
	int          low_cnt;
	int          frame_low;
	logic [15:0] capq[$];

	initial
	begin
		{link_clk, frame_sync, sdata} = 3'h0;
		nbits = 0;
		low_cnt = 0;
		frame_low = 0;
		forever
		begin
			wait (run);
			// Bit clock only within frames; frames run back to back
			for (int s = 0; s <= int'(last_slot); s++)
				for (int b = 0; b < 16; b++)
				begin
					frame_sync = (s == 0 && b == 0);
					sdata      = words[s][15-b];
					#7.5 link_clk = 1'b1;
					#7.5;
					// Sampled late in the bit, clear of the drive edge
					if (oe_n === 1'b0)
					begin
						shift = {shift[14:0], pin};
						low_cnt++;
						nbits++;
						if (nbits == 16)
						begin
							capq.push_back(shift);
							nbits = 0;
						end
					end
					else
						nbits = 0;
					link_clk = 1'b0;
				end
			frame_low  = low_cnt;
			low_cnt    = 0;
			frame_sync = 1'b0;
			sdata      = ~sdata;
		end
	end
endmodule // asf_codec

// ===== verification/asf_audio_slot_fifo_tb.sv
`timescale 1ns/1ps
module asf_audio_slot_fifo_tb import asf_pkg::*;;
	logic clk, rst_n, link_clk, frame_sync, serial_rx_data, pin_o, pin_oe_n;
	logic interface_enable_bit, rx_rd, rx_overflow_clear, tsc_wr, tx_wr;
	logic rx_fifo_full_flag, rx_fifo_empty_flag, rx_overflow_flag;
	logic rx_irq, tx_irq;
	logic [1:0]  frame_last_slot;
	logic [3:0]  rx_slot_enables, rx_dma_slot_routing, rx_dma_request_enable;
	logic [3:0]  rx_warning_level, rx_dma_ack, tx_dma_wr, rx_dma_req, tx_dma_req;
	logic [15:0] tsc_wdata, tsc_rdata, tx_wdata, tx_dma_wdata, rx_rdata;
	logic [15:0] rnd;
	logic [15:0] txq[$];
	logic [3:0][15:0] rx_dma_data_reg, words;
	int n_mismatch, total_checks, cyc, n, j;

	asf_audio_slot_fifo DUT (.clk, .rst_n, .link_clk, .frame_sync, .serial_rx_data,
		.serial_tx_data_pin_o(pin_o), .serial_tx_data_pin_oe_n(pin_oe_n),
		.interface_enable_bit, .frame_last_slot, .rx_slot_enables,
		.rx_dma_slot_routing, .rx_dma_request_enable, .rx_warning_level, .tsc_wr,
		.tsc_wdata, .tsc_rdata, .rx_rd, .rx_rdata, .rx_fifo_full_flag,
		.rx_fifo_empty_flag, .rx_overflow_flag, .rx_overflow_clear, .tx_wr,
		.tx_wdata, .rx_dma_data_reg, .rx_dma_ack, .rx_dma_req, .tx_dma_wr,
		.tx_dma_wdata, .tx_dma_req, .rx_irq, .tx_irq);
	asf_codec codec (.run(interface_enable_bit), .last_slot(frame_last_slot), .words,
		.pin(pin_o), .oe_n(pin_oe_n), .link_clk, .frame_sync, .sdata(serial_rx_data));

	function automatic logic [15:0] xs();
		rnd ^= rnd << 7;
		rnd ^= rnd >> 9;
		rnd ^= rnd << 8;
		return rnd;
	endfunction
	task automatic chk(input string name, input logic [15:0] seen, exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic tsc_put(input logic [15:0] v);
		tsc_wdata = v;
		tsc_wr = 1'b1;
		step(1);
		tsc_wr = 1'b0;
		step(2);
	endtask
	task automatic close_out();
		if (n_mismatch == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 8000)
		begin
			n_mismatch++;
			close_out();
		end
	end

	initial
	begin
		{rst_n, interface_enable_bit, rx_rd, rx_overflow_clear, tsc_wr, tx_wr} = '0;
		{rx_slot_enables, rx_dma_slot_routing, rx_dma_request_enable} = '0;
		{rx_dma_ack, tx_dma_wr, tsc_wdata, tx_wdata, tx_dma_wdata} = '0;
		frame_last_slot = 2'h3;
		rx_warning_level = RX_LEVEL_RESET;
		rnd = 16'hFF33;
		for (int s = 0; s < 4; s++)
			words[s] = xs();
		step(10);
		rst_n = 1'b1;
		step(1);
		chk("tsc_reset", tsc_rdata, 16'hF00B);
		chk("reset_flags", 16'({tx_irq, rx_irq, rx_fifo_empty_flag, pin_oe_n,
			rx_dma_req, tx_dma_req}), 16'h0B00);
		tsc_put(16'h2231);
		chk("tsc_cfg", tsc_rdata, 16'h223B);
		chk("tx_dma_req", 16'(tx_dma_req), 16'h0002);
		tx_dma_wdata = xs();
		tx_dma_wr = 4'h2;
		step(1);
		tx_dma_wr = '0;
		step(1);
		chk("tx_dma_load", 16'(tx_dma_req), 16'h0000);
		// Link held off so the fill is not drained meanwhile
		tsc_put(16'h2011);
		for (int i = 0; i < 17; i++)
		begin
			tx_wdata = xs();
			tx_wr = 1'b1;
			step(1);
			tx_wr = 1'b0;
			if (txq.size() < 16)
				txq.push_back(tx_wdata);
			step(2);
			n = txq.size();
			chk("tx_flags", 16'({tx_irq, tsc_rdata[3:0]}),
				16'({n <= 2, n <= 2, n == 16, n == 0, 1'b1}));
		end
		rx_slot_enables = 4'h5;
		rx_dma_slot_routing = 4'h4;
		rx_dma_request_enable = 4'h4;
		interface_enable_bit = 1'b1;
		step(350);
		chk("rx_dma_req", 16'(rx_dma_req), 16'h0004);
		chk("rx_dma_word", rx_dma_data_reg[2], words[2]);
		chk("rx_irq", 16'(rx_irq), 16'h0001);
		rx_dma_ack = 4'h4;
		step(1);
		rx_dma_ack = '0;
		step(1);
		chk("rx_dma_ack", 16'(rx_dma_req), 16'h0000);
		step(2200);
		chk("rx_ovf", 16'({rx_fifo_full_flag, rx_overflow_flag, rx_irq,
			rx_dma_req}), 16'h0060);
		chk("tx_under", 16'({tsc_rdata[3:0], tx_irq}), 16'h0014);
		chk("oe_per_frame", 16'(codec.frame_low), 16'h0010);
		j = 0;
		while (j < codec.capq.size() && codec.capq[j] == 16'h0000)
			j++;
		for (int i = 0; i < 16; i++)
			chk("tx_word", codec.capq[j+i], txq[i]);
		chk("tx_resend", codec.capq[$], txq[15]);
		// Orderly shutdown: slots off, ten bit clocks, then disable
		rx_slot_enables = '0;
		tsc_put(16'h2001);
		repeat (DISABLE_WAIT_LINK_CYCLES) @(posedge link_clk);
		step(1);
		interface_enable_bit = 1'b0;
		step(200);
		rx_overflow_clear = 1'b1;
		step(1);
		rx_overflow_clear = 1'b0;
		step(1);
		chk("ovf_clear", 16'(rx_overflow_flag), 16'h0000);
		for (int i = 16; i > 0; i--)
		begin
			chk("rx_word", rx_rdata, words[0]);
			chk("rx_fill", 16'({rx_fifo_full_flag, rx_fifo_empty_flag}),
				16'({i == 16, 1'b0}));
			rx_rd = 1'b1;
			step(1);
			rx_rd = 1'b0;
			step(2);
		end
		chk("rx_drained", 16'({rx_fifo_empty_flag, rx_irq}), 16'h0002);
		close_out();
	end
endmodule // asf_audio_slot_fifo_tb
